// ==== hw/isp_ee_if.sv ====
`timescale 1ns/1ns
`default_nettype none
interface isp_ee_if;
	logic start;
	logic busy;
	logic sel;
	logic sclk;
	logic sdi;
	// main block requests a load and watches it
	modport ctl (output start, input busy, input sel, input sclk, input sdi);
	modport eng (input start, output busy, output sel, output sclk, output sdi);
endinterface
`default_nettype wire

// ==== hw/isp_ee_loader.sv ====
`timescale 1ns/1ns
`default_nettype none
module isp_ee_loader #(
	parameter int LOAD_BITS = isp_pkg::EE_READ_BITS
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// link to main block
	isp_ee_if.eng ee
);
	localparam int HW = $clog2(isp_pkg::EE_HALF_CYC + 1);
	localparam int BW = $clog2(LOAD_BITS + 1);
	logic active_reg, active_next;
	logic sclk_reg, sclk_next;
	logic [HW-1:0] half_reg, half_next;
	logic [BW-1:0] bits_reg, bits_next;

	////////////////////////////////////////////////////////////
	// serial clock generator for automatic read
	always_comb begin
		active_next = active_reg;
		sclk_next = sclk_reg;
		half_next = half_reg;
		bits_next = bits_reg;
		if (!active_reg) begin
			if (ee.start) begin
				active_next = 1'b1;
				half_next = '0;
				bits_next = '0;
				sclk_next = 1'b0;
			end
		end else if (half_reg == HW'(isp_pkg::EE_HALF_CYC - 1)) begin
			half_next = '0;
			sclk_next = !sclk_reg;
			if (sclk_reg) begin
				bits_next = bits_reg + BW'(1);
				if (bits_reg == BW'(LOAD_BITS - 1))
					active_next = 1'b0; // load over
			end
		end else begin
			half_next = half_reg + HW'(1);
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			active_reg <= 1'b1; // load runs after hardware reset
			sclk_reg <= 1'b0;
			half_reg <= '0;
			bits_reg <= '0;
		end else begin
			active_reg <= active_next;
			sclk_reg <= sclk_next;
			half_reg <= half_next;
			bits_reg <= bits_next;
		end
	end

	// outputs of the engine
	assign ee.busy = active_reg;
	assign ee.sel = active_reg;
	assign ee.sclk = sclk_reg & active_reg;
	assign ee.sdi = 1'b0; // read command stream kept simple

	a_load_length: assert property (@(posedge sys_clk) disable iff (!rst_n)
		$rose(active_reg) |-> active_reg [*8])
		else $error("eeprom load ended too soon");
endmodule // isp_ee_loader
`default_nettype wire

// ==== hw/isp_pkg.sv ====
package isp_pkg;
	// i/o window and address prom decode
	localparam logic [15:0] IO_BASE_RESET = 16'h0300;
	localparam int IO_ADDR_BITS = 5;
	localparam int APROM_BYTES = 16;
	localparam logic [4:0] IO_EE_CTRL_LO = 5'h10;
	localparam logic [4:0] IO_EE_CTRL_HI = 5'h11;
	localparam logic [4:0] IO_SLV_CFG_LO = 5'h12;
	localparam logic [4:0] IO_SLV_CFG_HI = 5'h13;
	localparam logic [4:0] IO_SRAM_DATA = 5'h14;
	// eeprom control register fields
	localparam int EE_PORT_EN_BIT = 4;
	localparam int EE_SELECT_BIT = 3;
	localparam int EE_CLOCK_BIT = 2;
	localparam int EE_DATA_IN_BIT = 1;
	localparam int EE_DATA_OUT_BIT = 0;
	localparam int EE_CHECKSUM_ERR_BIT = 15;
	localparam int EE_RELOAD_BIT = 14;
	localparam logic [15:0] EE_CTRL_RESET = 16'h0000;
	// slave configuration register fields
	localparam int PIO_SELECT_BIT = 13;
	localparam int FLASH_BOOT_BIT = 12;
	localparam int FLASH_FITTED_BIT = 11;
	localparam int EXT_DETECT_BIT = 10;
	localparam int AUI_SELECT_BIT = 9;
	localparam logic [15:0] SLV_CFG_RESET = 16'h0000;
	// timing
	localparam int CLK_HZ = 50_000_000;
	localparam int CRYSTAL_HZ = 20_000_000;
	localparam int RESET_MIN_XTAL = 10;
	localparam int RESET_MIN_CYC =
		(RESET_MIN_XTAL * CLK_HZ + CRYSTAL_HZ - 1) / CRYSTAL_HZ;
	localparam int RDY_WAIT_CYC = 2;
	localparam int EE_READ_BITS = 64;
	localparam int EE_HALF_CYC = 4;
	// access sequencer states
	typedef enum logic [1:0] {
		ISP_IDLE = 2'b00,
		ISP_WAIT = 2'b01,
		ISP_DONE = 2'b11
	} isp_acc_type;
endpackage

// ==== hw/isp_slave_port.sv ====
// What this block does
// - ignore memory read during refresh
// - reset drives all outputs inactive
// - sixteen bit only after SBHE falls
// - drive data on reads, capture writes
// - address prom on first sixteen bytes
// - boot prom select on match and read
// - transceiver disable high for twisted pair
// - reject input OR internal match
// - active low indicators, remapped in detect mode
// - bit 4 maps eeprom onto data
// - shift busy only during eeprom load
// - low shift busy during load forces checksum error
// - eeprom select during load, or from bit 3 with port enabled
// - sleep resets, ignores inputs, wakes
// - strap sampled after reset, pio select
// - shared memory match with strobe direction
// - flash boot makes sram chip select
// - write enable sram or global
// - clock from fifty megahertz source
// - i/o only with AEN low, base match
// - IOCHRDY low until data ready
`timescale 1ns/1ns
`default_nettype none
module isp_slave_port #(
	parameter logic [15:0] IO_BASE = isp_pkg::IO_BASE_RESET,
	parameter int LOAD_BITS = isp_pkg::EE_READ_BITS
) (
	// clock and resets
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic sys_reset,
	input wire logic sleep_n,
	// isa host bus
	input wire logic aen,
	input wire logic [15:0] sa,
	input wire logic sbhe_n,
	input wire logic ior_n,
	input wire logic iow_n,
	input wire logic memr_n,
	input wire logic memw_n,
	input wire logic ref_n,
	input wire logic [15:0] sd_in,
	output logic [15:0] sd_out,
	output logic sd_oe,
	output logic iochrdy,
	output logic iocs16_n,
	// board match inputs and strap
	input wire logic boot_prom_match_n,
	input wire logic shared_memory_match_n,
	input wire logic slave_mode_strap,
	// private bus
	output logic [15:0] private_address_bus,
	input wire logic [7:0] private_data_bus_in,
	output logic [7:0] private_data_bus_out,
	output logic [7:0] private_data_bus_oe,
	output logic address_prom_select_n,
	output logic boot_prom_select_n,
	output logic sram_chip_select_n,
	output logic sram_output_enable_n,
	output logic sram_write_enable_n,
	output logic irq12,
	// eeprom
	output logic eeprom_select,
	input wire logic shift_busy_in,
	output logic shift_busy_out,
	output logic shift_busy_oe,
	// network side status and pins
	input wire logic link_up,
	input wire logic [2:0] led_sel_src,
	input wire logic start_frame_byte_delimiter,
	input wire logic serial_receive_data,
	input wire logic serial_receive_clock,
	input wire logic internal_match_reject,
	input wire logic transceiver_disable_in,
	output logic transceiver_disable_out,
	output logic transceiver_disable_oe,
	output logic frame_reject,
	output logic [3:0] led_n,
	// mode state for the controller
	output logic slave_mode,
	output logic pio_mode,
	output logic wide_enabled
);
	logic int_reset;
	isp_ee_if ee();
	isp_pkg::isp_acc_type acc_reg, acc_next;
	logic [15:0] ee_ctrl_reg, ee_ctrl_next;
	logic [15:0] slv_cfg_reg, slv_cfg_next;
	logic wide_reg, wide_next;
	logic sbhe_d_reg, sbhe_d_next;
	logic strap_reg, strap_next;
	logic strap_done_reg, strap_done_next;
	logic [15:0] rd_reg, rd_next;
	logic [1:0] wait_reg, wait_next;
	logic start_reg, start_next;
	logic io_hit, io_rd, io_wr, mem_rd, aprom_hit, boot_hit, smem_hit;
	logic ee_port, ext_detect, cycle;
	logic [7:0] hi_byte;
	logic [4:0] io_off;

	////////////////////////////////////////////////////////////
	// internal reset, held one cycle past pin and sleep
	isp_sync_reset u_rst (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.sys_reset(sys_reset),
		.sleep_n(sleep_n),
		.int_reset(int_reset)
	);

	// automatic eeprom read engine
	isp_ee_loader #(.LOAD_BITS(LOAD_BITS)) u_ee (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.ee(ee.eng)
	);

	////////////////////////////////////////////////////////////
	// decode of host cycles
	assign io_off = sa[4:0];
	assign io_hit = !aen && (sa[15:5] == IO_BASE[15:5]);
	assign io_rd = io_hit && !ior_n;
	assign io_wr = io_hit && !iow_n;
	assign mem_rd = !memr_n && ref_n;
	assign aprom_hit = io_rd && (io_off < 5'(isp_pkg::APROM_BYTES));
	assign boot_hit = mem_rd && !boot_prom_match_n;
	assign smem_hit = !pio_mode && !shared_memory_match_n &&
		(mem_rd || !memw_n);
	assign cycle = io_rd || io_wr || boot_hit || smem_hit;
	assign ee_port = ee_ctrl_reg[isp_pkg::EE_PORT_EN_BIT];
	assign ext_detect = slv_cfg_reg[isp_pkg::EXT_DETECT_BIT];
	// odd byte on low lane until 16-bit cycles are allowed
	assign hi_byte = (wide_reg && !sbhe_n) ? sd_in[15:8] : sd_in[7:0];

	////////////////////////////////////////////////////////////
	// registers, strap capture and 16-bit enable
	always_comb begin
		ee_ctrl_next = ee_ctrl_reg;
		slv_cfg_next = slv_cfg_reg;
		sbhe_d_next = sbhe_n;
		wide_next = wide_reg;
		strap_next = strap_reg;
		strap_done_next = 1'b1;
		start_next = 1'b0;
		if (sbhe_d_reg && !sbhe_n)
			wide_next = 1'b1;
		if (!strap_done_reg)
			strap_next = slave_mode_strap;
		if (ee.busy && !shift_busy_in)
			ee_ctrl_next[isp_pkg::EE_CHECKSUM_ERR_BIT] = 1'b1;
		if (io_wr && acc_reg == isp_pkg::ISP_IDLE) begin
			case (io_off)
			isp_pkg::IO_EE_CTRL_LO: ee_ctrl_next[7:0] = sd_in[7:0];
			isp_pkg::IO_EE_CTRL_HI: begin
				ee_ctrl_next[14:8] = {1'b0, hi_byte[5:0]};
				start_next = hi_byte[isp_pkg::EE_RELOAD_BIT - 8];
			end
			isp_pkg::IO_SLV_CFG_LO: slv_cfg_next[7:0] = sd_in[7:0];
			isp_pkg::IO_SLV_CFG_HI: slv_cfg_next[15:8] = hi_byte;
			default: ;
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			ee_ctrl_reg <= isp_pkg::EE_CTRL_RESET;
			slv_cfg_reg <= isp_pkg::SLV_CFG_RESET;
			wide_reg <= 1'b0;
			sbhe_d_reg <= 1'b1;
			strap_reg <= 1'b1;
			strap_done_reg <= 1'b0;
			start_reg <= 1'b0;
		end else if (int_reset) begin
			ee_ctrl_reg <= isp_pkg::EE_CTRL_RESET;
			slv_cfg_reg <= isp_pkg::SLV_CFG_RESET;
			wide_reg <= 1'b0;
			sbhe_d_reg <= 1'b1;
			strap_done_reg <= 1'b0;
			start_reg <= sys_reset; // pin reset reloads eeprom
		end else begin
			ee_ctrl_reg <= ee_ctrl_next;
			slv_cfg_reg <= slv_cfg_next;
			wide_reg <= wide_next;
			sbhe_d_reg <= sbhe_d_next;
			strap_reg <= strap_next;
			strap_done_reg <= strap_done_next;
			start_reg <= start_next;
		end
	end

	assign ee.start = start_reg;

	////////////////////////////////////////////////////////////
	// access sequencer and read data
	always_comb begin
		acc_next = acc_reg;
		wait_next = wait_reg;
		rd_next = rd_reg;
		case (acc_reg)
		isp_pkg::ISP_IDLE: begin
			if (cycle) begin
				acc_next = isp_pkg::ISP_WAIT;
				wait_next = 2'(isp_pkg::RDY_WAIT_CYC - 1);
			end
		end
		isp_pkg::ISP_WAIT: begin
			if (!cycle)
				acc_next = isp_pkg::ISP_IDLE;
			else if (wait_reg == 2'h0) begin
				acc_next = isp_pkg::ISP_DONE;
				rd_next = 16'h0000;
				if (aprom_hit || boot_hit || smem_hit)
					rd_next = {8'h00, private_data_bus_in};
				else if (io_off == isp_pkg::IO_EE_CTRL_LO)
					rd_next = {8'h00, ee_ctrl_reg[7:3],
						ee_port ? private_data_bus_in[2] : 1'b0,
						ee_ctrl_reg[1:0]};
				else if (io_off == isp_pkg::IO_EE_CTRL_HI)
					rd_next = {2{ee_ctrl_reg[15:8]}}; // both lanes
				else if (io_off == isp_pkg::IO_SLV_CFG_LO)
					rd_next = {8'h00, slv_cfg_reg[7:0]};
				else if (io_off == isp_pkg::IO_SLV_CFG_HI)
					rd_next = {2{slv_cfg_reg[15:8]}}; // both lanes
			end else
				wait_next = wait_reg - 2'h1;
		end
		isp_pkg::ISP_DONE: begin
			if (!cycle)
				acc_next = isp_pkg::ISP_IDLE;
		end
		default: acc_next = isp_pkg::ISP_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			acc_reg <= isp_pkg::ISP_IDLE;
			wait_reg <= 2'h0;
			rd_reg <= 16'h0000;
		end else if (int_reset) begin
			acc_reg <= isp_pkg::ISP_IDLE;
			wait_reg <= 2'h0;
			rd_reg <= 16'h0000;
		end else begin
			acc_reg <= acc_next;
			wait_reg <= wait_next;
			rd_reg <= rd_next;
		end
	end

	////////////////////////////////////////////////////////////
	// host bus outputs
	assign sd_out = rd_reg;
	assign sd_oe = !int_reset && (io_rd || boot_hit || (smem_hit && mem_rd));
	assign iochrdy = !(cycle && !int_reset) ||
		(acc_reg == isp_pkg::ISP_DONE);
	assign iocs16_n = !(io_hit && wide_reg && !aprom_hit && !int_reset);

	// private bus strobes, one device at a time
	assign private_address_bus = int_reset ? 16'h0000 : sa;
	assign address_prom_select_n = !(aprom_hit && !int_reset);
	assign boot_prom_select_n = !(boot_hit && !int_reset && !aprom_hit);
	assign sram_chip_select_n = !(slv_cfg_reg[isp_pkg::FLASH_BOOT_BIT] &&
		smem_hit && !boot_hit && !int_reset);
	assign irq12 = 1'b0;
	assign sram_output_enable_n = !(smem_hit && mem_rd && !boot_hit &&
		!int_reset);
	assign sram_write_enable_n = !(!int_reset && !memw_n &&
		(smem_hit || slv_cfg_reg[isp_pkg::FLASH_FITTED_BIT] &&
		!boot_prom_match_n));

	// private data bits 0..2 become eeprom port
	always_comb begin
		private_data_bus_out = 8'h00;
		private_data_bus_oe = 8'h00;
		if (!int_reset && ee_port) begin
			private_data_bus_out[0] = ee_ctrl_reg[isp_pkg::EE_CLOCK_BIT];
			private_data_bus_out[1] = ee_ctrl_reg[isp_pkg::EE_DATA_IN_BIT];
			private_data_bus_oe[1:0] = 2'b11;
		end else if (!int_reset && ee.busy) begin
			private_data_bus_out[0] = ee.sclk;
			private_data_bus_out[1] = ee.sdi;
			private_data_bus_oe[1:0] = 2'b11;
		end else if (!sram_write_enable_n) begin
			private_data_bus_out = sd_in[7:0];
			private_data_bus_oe = 8'hff;
		end
	end
	assign eeprom_select = !int_reset && (ee.sel ||
		(ee_port && ee_ctrl_reg[isp_pkg::EE_SELECT_BIT]));
	assign shift_busy_out = ee.busy && !int_reset;
	assign shift_busy_oe = shift_busy_out;

	// network pins and indicators
	assign transceiver_disable_oe = !ext_detect;
	assign transceiver_disable_out = int_reset ||
		!slv_cfg_reg[isp_pkg::AUI_SELECT_BIT];
	assign frame_reject = ext_detect && !int_reset &&
		(!transceiver_disable_in || internal_match_reject);
	assign led_n = int_reset ? 4'hf : ext_detect ?
		{!serial_receive_clock, !serial_receive_data,
		!start_frame_byte_delimiter, !link_up} :
		{~led_sel_src, !link_up};

	assign slave_mode = !strap_reg;
	assign pio_mode = slv_cfg_reg[isp_pkg::PIO_SELECT_BIT];
	assign wide_enabled = wide_reg;

	a_refresh_blocks: assert property (@(posedge sys_clk) disable iff (!rst_n)
		!ref_n |-> boot_prom_select_n)
		else $error("read during refresh");
	a_aprom_narrow: assert property (@(posedge sys_clk) disable iff (!rst_n)
		!address_prom_select_n |-> iocs16_n)
		else $error("iocs16 on address prom");
	a_narrow_first: assert property (@(posedge sys_clk) disable iff (!rst_n)
		!wide_reg |-> iocs16_n)
		else $error("wide before sbhe edge");
	a_rdy_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
		($rose(cycle) && !int_reset) |-> !iochrdy [*2])
		else $error("ready too early");
	a_one_select: assert property (@(posedge sys_clk) disable iff (!rst_n)
		$onehot0({!address_prom_select_n, !boot_prom_select_n,
		!sram_chip_select_n}))
		else $error("two private selects");
	a_aen_gate: assert property (@(posedge sys_clk) disable iff (!rst_n)
		aen |-> iocs16_n && address_prom_select_n)
		else $error("io honoured with aen high");
	a_reset_quiet: assert property (@(posedge sys_clk) disable iff (!rst_n)
		int_reset |-> !sd_oe && led_n == 4'hf && !eeprom_select)
		else $error("outputs live in reset");
	a_ee_pins: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(ee_port && !int_reset) |-> private_data_bus_oe[1:0] == 2'b11 &&
		!private_data_bus_oe[2])
		else $error("eeprom pins wrong");
endmodule // isp_slave_port
`default_nettype wire

// ==== hw/isp_sync_reset.sv ====
`timescale 1ns/1ns
`default_nettype none
module isp_sync_reset #(
	parameter int HOLD = isp_pkg::RESET_MIN_CYC
) (
	// clock and raw reset sources
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic sys_reset,
	input wire logic sleep_n,
	// combined internal reset, active high
	output logic int_reset
);
	localparam int CW = $clog2(HOLD + 1);
	logic [CW-1:0] cnt_reg, cnt_next;
	logic hold_reg, hold_next;

	////////////////////////////////////////////////////////////
	// reset held while pin or sleep active
	always_comb begin
		cnt_next = cnt_reg;
		hold_next = hold_reg;
		if (sys_reset || !sleep_n) begin
			hold_next = 1'b1;
			cnt_next = '0;
		end else if (hold_reg) begin
			hold_next = 1'b0;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_reg <= '0;
			hold_reg <= 1'b1;
		end else begin
			cnt_reg <= cnt_next;
			hold_reg <= hold_next;
		end
	end

	assign int_reset = hold_reg;

	a_sleep_reset: assert property (@(posedge sys_clk) disable iff (!rst_n)
		!sleep_n |=> int_reset)
		else $error("sleep did not reset");
endmodule // isp_sync_reset
`default_nettype wire

// ==== verif/isp_host_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module isp_host_model (
	// clock
	input wire logic sys_clk,
	// device answers
	input wire logic iochrdy,
	input wire logic sd_oe,
	input wire logic [15:0] sd_out,
	// host strobes and data
	output logic aen,
	output logic [15:0] sa,
	output logic sbhe_n,
	output logic ior_n,
	output logic iow_n,
	output logic memr_n,
	output logic memw_n,
	output logic ref_n,
	output logic [15:0] sd_in,
	// results for the bench
	output logic rd_done,
	output logic [15:0] rd_data,
	output logic hung
);
	// idle bus, no memory writes from this host
	initial begin
		{aen, sbhe_n, ior_n, iow_n, memr_n, memw_n, ref_n} = 7'h7f;
		sa = 16'h0000;
		sd_in = 16'h0000;
		{rd_done, hung} = 2'b00;
		rd_data = 16'h0000;
	end

	////////////////////////////////////////////////////////////////////////
	// low byte as seen on the bus, zero when nobody drives it
	function automatic logic [15:0] seen();
		return sd_oe ? {8'h01, sd_out[7:0]} : 16'h0000;
	endfunction

	// i/o cycle held until ready is seen high at a falling edge
	task automatic io(input logic en_n, input logic wr, input logic wide,
		input logic [15:0] addr, input logic [7:0] data);
		int n;
		logic rdy;
		logic [15:0] got;
		n = 0;
		@(negedge sys_clk);
		aen = en_n;
		sa = addr;
		sbhe_n = ~wide;
		sd_in = wr ? {8'h00, data} : ~sd_in;
		iow_n = ~wr;
		ior_n = wr;
		do begin
			@(negedge sys_clk);
			rdy = iochrdy;
			got = seen();
			@(posedge sys_clk);
			n++;
		end while (rdy !== 1'b1 && n < 40);
		finish(wr, got, n);
	endtask

	// memory read, optionally refresh; memcs16 left to board
	task automatic mem(input logic refresh);
		logic [15:0] got;
		@(negedge sys_clk);
		ref_n = ~refresh;
		memr_n = 1'b0;
		repeat (3) @(negedge sys_clk);
		got = seen();
		@(posedge sys_clk);
		finish(1'b0, got, 0);
	endtask

	// release everything, hand the result over for one cycle
	task automatic finish(input logic wr, input logic [15:0] got, input int n);
		hung = hung | (n >= 40);
		@(negedge sys_clk);
		rd_data = got;
		rd_done = ~wr;
		{aen, sbhe_n, ior_n, iow_n, memr_n, ref_n} = 6'h3f;
		sd_in = ~sd_in;
		@(negedge sys_clk);
		rd_done = 1'b0;
	endtask
endmodule // isp_host_model
`default_nettype wire

// ==== verif/isp_slave_port_test.sv ====
`timescale 1ns/1ns
`default_nettype none
module isp_slave_port_test;
	// bench driven inputs
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic sys_reset = 1'b0;
	logic sleep_n = 1'b1;
	logic boot_prom_match_n = 1'b1;
	logic shared_memory_match_n = 1'b1; // tied high in pio mode
	logic slave_mode_strap = 1'b0;
	logic [7:0] private_data_bus_in = 8'h00;
	logic link_up = 1'b0;
	logic [2:0] led_sel_src = 3'h0;
	logic start_frame_byte_delimiter = 1'b0;
	logic serial_receive_data = 1'b0;
	logic serial_receive_clock = 1'b0;
	logic internal_match_reject = 1'b0;
	logic reject_n = 1'b1;
	logic busy_pull_dn = 1'b0;
	// host and device outputs
	logic aen, sbhe_n, ior_n, iow_n, memr_n, memw_n, ref_n, rd_done, hung;
	logic [15:0] sa, sd_in, sd_out, rd_data, private_address_bus;
	logic sd_oe, iochrdy, iocs16_n, address_prom_select_n, boot_prom_select_n;
	logic sram_chip_select_n, sram_output_enable_n, sram_write_enable_n, irq12;
	logic [7:0] private_data_bus_out, private_data_bus_oe;
	logic eeprom_select, shift_busy_out, shift_busy_oe, transceiver_disable_out;
	logic transceiver_disable_oe, frame_reject, slave_mode, pio_mode;
	logic wide_enabled;
	logic [3:0] led_n;
	wire logic shift_busy_in;
	wire logic transceiver_disable_in;
	int seed = 59;
	int failures = 0;
	int comparisons = 0;
	logic [15:0] exp_q[$];
	logic [7:0] v;

	// board pull-up on shift busy, which may be held low; transceiver disable reads reject_n when undriven
	assign shift_busy_in = busy_pull_dn ? 1'b0 :
		shift_busy_oe ? shift_busy_out : 1'b1;
	assign transceiver_disable_in =
		transceiver_disable_oe ? transceiver_disable_out : reject_n;

	// 50 mhz clock
	always #10 sys_clk = ~sys_clk;

	isp_slave_port #(.LOAD_BITS(4)) dut (.sys_clk, .rst_n, .sys_reset,
		.sleep_n, .aen, .sa, .sbhe_n, .ior_n, .iow_n, .memr_n, .memw_n,
		.ref_n, .sd_in, .sd_out, .sd_oe, .iochrdy, .iocs16_n,
		.boot_prom_match_n, .shared_memory_match_n, .slave_mode_strap,
		.private_address_bus, .private_data_bus_in, .private_data_bus_out,
		.private_data_bus_oe, .address_prom_select_n, .boot_prom_select_n,
		.sram_chip_select_n, .sram_output_enable_n, .sram_write_enable_n,
		.irq12, .eeprom_select, .shift_busy_in, .shift_busy_out,
		.shift_busy_oe, .link_up, .led_sel_src, .start_frame_byte_delimiter,
		.serial_receive_data, .serial_receive_clock, .internal_match_reject,
		.transceiver_disable_in, .transceiver_disable_out,
		.transceiver_disable_oe, .frame_reject, .led_n, .slave_mode,
		.pio_mode, .wide_enabled);
	isp_host_model host (.sys_clk, .iochrdy, .sd_oe, .sd_out, .aen, .sa,
		.sbhe_n, .ior_n, .iow_n, .memr_n, .memw_n, .ref_n, .sd_in, .rd_done,
		.rd_data, .hung);

	////////////////////////////////////////////////////////////////////////
	// compare and count
	task automatic check(input logic [15:0] got, input logic [15:0] want,
		input string what);
		comparisons++;
		if (got !== want) begin
			failures++;
			$display("wrong value at %0t: %s", $time, what);
		end
	endtask

	// oldest note against each read result
	always @(posedge sys_clk) begin
		if (rd_done === 1'b1) begin
			if (exp_q.size() == 0)
				check(16'h0001, 16'h0000, "read without note");
			else
				check(rd_data, exp_q.pop_front(), "read data");
		end
	end

	// bus helpers and load wait
	task automatic rd(input logic [15:0] addr, input logic [15:0] want);
		exp_q.push_back(want);
		host.io(1'b0, 1'b0, 1'b0, addr, 8'h00);
	endtask
	task automatic wr(input logic [4:0] off, input logic [7:0] d);
		host.io(1'b0, 1'b1, 1'b0, isp_pkg::IO_BASE_RESET | {11'h000, off}, d);
	endtask
	task automatic wait_load();
		int n;
		n = 0;
		while (shift_busy_out !== 1'b0 && n < 1000) begin
			@(negedge sys_clk);
			n++;
		end
		check(eeprom_select, 1'b0, "select after load");
	endtask

	// verdict
	task automatic report_and_stop();
		if (hung === 1'b1)
			failures++;
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// watchdog
	initial begin
		repeat (20000) @(posedge sys_clk);
		failures++;
		$display("wrong value at %0t: watchdog expired", $time);
		report_and_stop();
	end

	////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		repeat (6) @(negedge sys_clk);
		check({sd_oe, address_prom_select_n, boot_prom_select_n,
			sram_chip_select_n, led_n}, 8'h7f, "reset levels");
		repeat (6) @(negedge sys_clk);
		rst_n = 1'b1;
		repeat (3) @(negedge sys_clk);
		check({shift_busy_out, eeprom_select}, 2'b11, "load");
		wait_load();
		check({slave_mode, wide_enabled}, 2'b10, "strap");
		$display("test reset done");
		for (int i = 0; i < 16; i += 5) begin
			private_data_bus_in = 8'($random(seed));
			rd(16'h0300 + 16'(i), {8'h01, private_data_bus_in});
		end
		exp_q.push_back(16'h0000);
		host.io(1'b1, 1'b0, 1'b0, 16'h0300, 8'h00);
		rd(16'h03e0, 16'h0000);
		$display("test address prom done");
		for (int a = 0; a < 2; a++) begin
			v = (8'($random(seed)) & 8'h38) | 8'(a << 1);
			wr(5'h13, v);
			rd(16'h0313, {8'h01, v});
			check({pio_mode, transceiver_disable_out, transceiver_disable_oe},
				{v[5], ~v[1], 1'b1}, "mode outputs");
		end
		wr(5'h13, 8'h04);
		for (int k = 0; k < 4; k++) begin
			{reject_n, internal_match_reject} = 2'(k);
			{link_up, start_frame_byte_delimiter, serial_receive_data,
				serial_receive_clock} = 4'($random(seed));
			led_sel_src = 3'($random(seed));
			@(negedge sys_clk);
			check({transceiver_disable_oe, frame_reject},
				{1'b0, internal_match_reject | ~reject_n}, "reject");
			check(led_n, 4'(~{serial_receive_clock, serial_receive_data,
				start_frame_byte_delimiter, link_up}), "indicators");
		end
		wr(5'h13, 8'h00);
		check(led_n, 4'(~{led_sel_src, link_up}), "indicators normal");
		$display("test configuration done");
		boot_prom_match_n = 1'b0;
		private_data_bus_in = 8'($random(seed));
		exp_q.push_back({8'h01, private_data_bus_in});
		host.mem(1'b0);
		exp_q.push_back(16'h0000);
		host.mem(1'b1);
		boot_prom_match_n = 1'b1;
		exp_q.push_back(16'h0100);
		host.io(1'b0, 1'b0, 1'b1, 16'h0313, 8'h00);
		check(wide_enabled, 1'b1, "wide after sbhe");
		$display("test boot prom done");
		wr(5'h10, 8'h1e);
		check({eeprom_select, private_data_bus_out[1:0],
			private_data_bus_oe[2:0]}, 6'h3b, "eeprom pins");
		wr(5'h10, 8'h10);
		check(private_data_bus_out[1:0], 2'b00, "eeprom pins low");
		wr(5'h10, 8'h00);
		rd(16'h0311, 16'h0100);
		busy_pull_dn = 1'b1;
		wr(5'h11, 8'h40);
		repeat (2) @(negedge sys_clk);
		check(shift_busy_out, 1'b1, "reload busy");
		wait_load();
		busy_pull_dn = 1'b0;
		rd(16'h0311, 16'h0180);
		$display("test eeprom done");
		wr(5'h13, 8'h20);
		sleep_n = 1'b0;
		repeat (4) @(negedge sys_clk);
		check({sd_oe, transceiver_disable_out, pio_mode}, 3'b010,
			"sleep levels");
		sleep_n = 1'b1;
		repeat (3) @(negedge sys_clk); // short settle wait
		wait_load();
		rd(16'h0313, 16'h0100);
		repeat (4) @(negedge sys_clk);
		$display("test sleep done");
		shared_memory_match_n = 1'b0;
		private_data_bus_in = 8'($random(seed));
		exp_q.push_back({8'h01, private_data_bus_in});
		host.mem(1'b0);
		shared_memory_match_n = 1'b1;
		slave_mode_strap = 1'b1;
		sys_reset = 1'b1;
		repeat (isp_pkg::RESET_MIN_CYC) @(negedge sys_clk);
		check({sd_oe, led_n}, 5'h0f, "pin reset levels");
		sys_reset = 1'b0;
		repeat (3) @(negedge sys_clk);
		check({shift_busy_out, eeprom_select, slave_mode}, 3'b110,
			"pin reset load");
		wait_load();
		rd(16'h0313, 16'h0100);
		repeat (4) @(negedge sys_clk);
		$display("test pin reset done");
		report_and_stop();
	end
endmodule // isp_slave_port_test
`default_nettype wire
